// ---- rtl/frt_timer_defs.vh ----
// Register map, field positions, reset values and timing figures of the tick timer
`ifndef FRT_TIMER_DEFS_VH
`define FRT_TIMER_DEFS_VH

// I/O memory addresses of the nibble registers
`define FRT_ADDR_FLAGS        8'hC6
`define FRT_ADDR_ENABLES      8'hCC
`define FRT_ADDR_CLEAR_CTRL   8'hE2
`define FRT_ADDR_CNT_LOW      8'hE3
`define FRT_ADDR_CNT_HIGH     8'hE4

// Bit positions inside the flag and enable nibbles
`define FRT_BIT_32HZ          0
`define FRT_BIT_8HZ           1
`define FRT_BIT_2HZ           2
`define FRT_BIT_1HZ           3

// Counter bit that carries each tap frequency
`define FRT_CNT_BIT_32HZ      2
`define FRT_CNT_BIT_8HZ       4
`define FRT_CNT_BIT_2HZ       6
`define FRT_CNT_BIT_1HZ       7

// Clear bit of the control nibble
`define FRT_BIT_CLEAR         0

// Reset values
`define FRT_RST_FLAGS         4'h0
`define FRT_RST_ENABLES       4'h0
`define FRT_RST_COUNT         8'h00
`define FRT_RST_NIBBLE        4'h0

// Carry hold window: least figure, clock period, both in ns
`define FRT_HOLD_TIME_NS      480000
`define FRT_CLK_PERIOD_NS     40
`define FRT_HOLD_CYCLES       ((`FRT_HOLD_TIME_NS + `FRT_CLK_PERIOD_NS - 1) / `FRT_CLK_PERIOD_NS)

`endif

// ---- rtl/frt_tick_edge.v ----
// Two-flop synchroniser and rising-edge pulse for the 256 Hz tick pin
module frt_tick_edge (
    input  wire ref_clk,
    input  wire rst_sync_n,
    input  wire tick_in,
    output reg  tick_pulse
);

    reg sync_a_reg;
    reg sync_b_reg;
    reg sync_c_reg;

    // Stage a feeds only stage b; edge logic looks at b and c
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
            sync_c_reg <= 1'b0;
            tick_pulse <= 1'b0;
        end else begin
            sync_a_reg <= tick_in;
            sync_b_reg <= sync_a_reg;
            sync_c_reg <= sync_b_reg;
            tick_pulse <= sync_b_reg & ~sync_c_reg;
        end
    end

endmodule

// ---- rtl/frt_tick_timer.v ----
// Free-running 256 Hz tick counter with tap flags, enables and carry hold
`include "frt_timer_defs.vh"

// Overview of operation
// - Each 32, 8, 2 and 1 Hz tap sets its flag on its falling edge.
// - Flags set regardless of enable; enables gate only the request.
// - One enable bit per tap, one enables, reads back as written.
// - Flag nibble: 1 Hz bit 3, 2 Hz bit 2, 8 Hz bit 1, 32 Hz bit 0.
// - Enable nibble uses the same bit order as the flag nibble.
// - Reading the flag nibble returns flags then clears all four.
// - Flag writes are ignored; flags are zero after initial reset.
// - All enable bits are zero, masked, after initial reset.
// - Writing one to clear bit zeroes counter, counting resumes; zero does nothing.
// - The same clear write pulses the watchdog clear strobe.
// - Clear bit and three upper control bits always read zero.
// - Counter readable as two nibbles, writes ignored, zero after reset.
// - Low nibble holds 128..16 Hz bits, high nibble 8..1 Hz bits.
// - Eight-bit binary up-counter stepped by the 256 Hz tick.
// - Low read holds carries into high nibble until high read or timeout.
module frt_tick_timer #(
    parameter HOLD_CYCLES = `FRT_HOLD_CYCLES
) (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       tick_256hz,
    input  wire [7:0] io_addr,
    input  wire [3:0] io_wdata,
    input  wire       io_wr,
    input  wire       io_rd,
    output reg  [3:0] io_rdata,
    output reg        irq_out,
    output reg        counter_clear_strobe
);

    // Window counter width; the part-select keeps the last count at that width
    localparam HOLD_W = 24;
    localparam [HOLD_W-1:0] HOLD_LAST = HOLD_CYCLES[HOLD_W-1:0] - {{(HOLD_W-1){1'b0}}, 1'b1};

    reg              rst_meta_reg;
    reg              rst_sync_n;
    wire             tick_pulse;
    reg  [3:0]       counter_low_bits;
    reg  [3:0]       counter_high_bits;
    reg  [3:0]       flags_reg;
    reg  [3:0]       enables_reg;
    reg  [3:0]       taps_prev_reg;
    reg              hold_reg;
    reg              carry_pend_reg;
    reg  [HOLD_W-1:0] hold_cnt_reg;
    reg  [3:0]       low_next;
    reg  [3:0]       high_next;
    reg              hold_next;
    reg              pend_next;
    reg  [3:0]       rdata_next;
    reg              do_carry;
    wire [3:0]       taps_now;
    wire [3:0]       tap_fall;
    wire [3:0]       flags_next;
    wire             hit_flags;
    wire             hit_enables;
    wire             hit_ctrl;
    wire             hit_low;
    wire             hit_high;
    wire             clear_cmd;
    wire             hold_timeout;

    // Pick the four tap bits out of a counter value, in flag nibble order
    function [3:0] frt_taps;
        input [7:0] cnt;
        begin
            frt_taps = 4'h0;
            frt_taps[`FRT_BIT_32HZ] = cnt[`FRT_CNT_BIT_32HZ];
            frt_taps[`FRT_BIT_8HZ]  = cnt[`FRT_CNT_BIT_8HZ];
            frt_taps[`FRT_BIT_2HZ]  = cnt[`FRT_CNT_BIT_2HZ];
            frt_taps[`FRT_BIT_1HZ]  = cnt[`FRT_CNT_BIT_1HZ];
        end
    endfunction

    // Reset release through two flops so all logic leaves reset together
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    frt_tick_edge u_tick_edge (
        .ref_clk    (ref_clk),
        .rst_sync_n (rst_sync_n),
        .tick_in    (tick_256hz),
        .tick_pulse (tick_pulse)
    );

    // Address decode of the CPU nibble bus
    assign hit_flags   = (io_addr == `FRT_ADDR_FLAGS);
    assign hit_enables = (io_addr == `FRT_ADDR_ENABLES);
    assign hit_ctrl    = (io_addr == `FRT_ADDR_CLEAR_CTRL);
    assign hit_low     = (io_addr == `FRT_ADDR_CNT_LOW);
    assign hit_high    = (io_addr == `FRT_ADDR_CNT_HIGH);
    assign clear_cmd   = io_wr & hit_ctrl & io_wdata[`FRT_BIT_CLEAR];
    assign hold_timeout = hold_reg && (hold_cnt_reg == HOLD_LAST);

    // counter stepping, with the carry into the high nibble held
    always @* begin
        low_next  = counter_low_bits;
        high_next = counter_high_bits;
        hold_next = hold_reg;
        pend_next = carry_pend_reg;
        do_carry  = 1'b0;
        if (tick_pulse) begin
            low_next = counter_low_bits + 4'h1;
            do_carry = (counter_low_bits == 4'hF);
        end
        // hold window opens on a low read, closes on high read or timeout
        if (io_rd && hit_low) begin
            hold_next = 1'b1;
        end else if ((io_rd && hit_high) || hold_timeout) begin
            hold_next = 1'b0;
        end
        if (hold_next) begin
            // Only one carry can arrive per window: low wraps every 62.5 ms
            pend_next = carry_pend_reg | do_carry;
        end else begin
            high_next = counter_high_bits
                      + {3'b000, (carry_pend_reg | do_carry)};
            pend_next = 1'b0;
        end
        // clear zeroes all bits and any pending hold
        if (clear_cmd) begin
            low_next  = `FRT_RST_NIBBLE;
            high_next = `FRT_RST_NIBBLE;
            hold_next = 1'b0;
            pend_next = 1'b0;
        end
    end

    // counter and hold state, zero after reset, writes never load them
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            counter_low_bits  <= `FRT_RST_NIBBLE;
            counter_high_bits <= `FRT_RST_NIBBLE;
            hold_reg          <= 1'b0;
            carry_pend_reg    <= 1'b0;
            hold_cnt_reg      <= {HOLD_W{1'b0}};
        end else begin
            counter_low_bits  <= low_next;
            counter_high_bits <= high_next;
            hold_reg          <= hold_next;
            carry_pend_reg    <= pend_next;
            // Window counter restarts on every low read
            if (!hold_next || (io_rd && hit_low)) begin
                hold_cnt_reg <= {HOLD_W{1'b0}};
            end else begin
                hold_cnt_reg <= hold_cnt_reg + {{(HOLD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // falling edge of each tap on the visible count
    assign taps_now = frt_taps({counter_high_bits, counter_low_bits});
    assign tap_fall = taps_prev_reg & ~taps_now;
    // read clears, but a fall in the same cycle still sets its flag
    assign flags_next = (flags_reg & ~{4{io_rd & hit_flags}}) | tap_fall;

    // flags set without regard to enables
    // flags take no writes and clear on reset
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            taps_prev_reg <= 4'h0;
            flags_reg     <= `FRT_RST_FLAGS;
            enables_reg   <= `FRT_RST_ENABLES;
        end else begin
            taps_prev_reg <= taps_now;
            flags_reg     <= flags_next;
            if (io_wr && hit_enables) begin
                enables_reg <= io_wdata;
            end
        end
    end

    // Read data mux; unmapped addresses answer zero
    always @* begin
        rdata_next = 4'h0;
        case (1'b1)
            hit_flags:   rdata_next = flags_reg;
            // enable nibble in the same order
            hit_enables: rdata_next = enables_reg;
            hit_ctrl:    rdata_next = 4'h0;
            hit_low:     rdata_next = counter_low_bits;
            hit_high:    rdata_next = counter_high_bits;
            default:     rdata_next = 4'h0;
        endcase
    end

    // Registered outputs: read data holds until the next read
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            io_rdata             <= 4'h0;
            irq_out              <= 1'b0;
            counter_clear_strobe <= 1'b0;
        end else begin
            if (io_rd) begin
                io_rdata <= rdata_next;
            end
            // request from flagged and enabled taps
            irq_out <= |(flags_next & enables_reg);
            // watchdog clear pulse on the same write
            counter_clear_strobe <= clear_cmd;
        end
    end

endmodule

// ---- test/frt_tick_timer_properties.sv ----
// Port-level assertions for the tick timer
`include "frt_timer_defs.vh"
module frt_tick_timer_properties #(
    parameter HOLD_CYCLES = 12000
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       tick_256hz,
    input wire logic [7:0] io_addr,
    input wire logic [3:0] io_wdata,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [3:0] io_rdata,
    input wire logic       irq_out,
    input wire logic       counter_clear_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] en_model;
    wire        clr_wr = io_wr && io_addr == `FRT_ADDR_CLEAR_CTRL && io_wdata[`FRT_BIT_CLEAR];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the enable nibble, so readback needs no view inside
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            en_model <= `FRT_RST_ENABLES;
        else if (io_wr && io_addr == `FRT_ADDR_ENABLES)
            en_model <= io_wdata;
    end
    property p_clear_strobe; clr_wr |=> counter_clear_strobe; endproperty
    a_clear_strobe: assert property (p_clear_strobe)
        else $error("clear write gave no strobe");
    property p_strobe_cause; counter_clear_strobe |-> $past(clr_wr); endproperty
    a_strobe_cause: assert property (p_strobe_cause)
        else $error("strobe without a clear write");
    property p_ctrl_zero; io_rd && io_addr == `FRT_ADDR_CLEAR_CTRL |=> io_rdata == 4'h0; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control nibble read not zero");
    property p_enables; io_rd && io_addr == `FRT_ADDR_ENABLES |=> io_rdata == en_model; endproperty
    a_enables: assert property (p_enables)
        else $error("enable nibble readback wrong");
    property p_irq_masked; irq_out |-> en_model != 4'h0 || $past(en_model) != 4'h0; endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("request raised with all taps masked");
    // An enable write one cycle back may still drop the request, so wait for stable enables
    property p_irq_holds;
        irq_out && !io_rd && !io_wr && en_model == $past(en_model) |=> irq_out;
    endproperty
    a_irq_holds: assert property (p_irq_holds)
        else $error("request dropped without a read");
    property p_reset_quiet;
        $rose(rst_n) |-> (io_rdata == 4'h0 && !irq_out && !counter_clear_strobe)[*2];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    property p_rdata_hold; !io_rd |=> $stable(io_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");
    c_clear: cover property (clr_wr ##1 counter_clear_strobe);
    c_irq: cover property ($rose(irq_out));
    c_tick: cover property ($rose(tick_256hz));
    c_flag_read: cover property (io_rd && io_addr == `FRT_ADDR_FLAGS ##1 io_rdata != 4'h0);
endmodule

bind frt_tick_timer frt_tick_timer_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .tick_256hz(tick_256hz), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .irq_out(irq_out), .counter_clear_strobe(counter_clear_strobe));

// ---- test/frt_osc_model.sv ----
// Compressed low-speed oscillator tick source
module frt_osc_model (
    input  wire logic ref_clk,
    output logic      tick
);
    timeunit 1ns;
    timeprecision 1ns;
    initial tick = 1'b0;
    // tick stepping: idles low, four cycles each phase, above the two-cycle minimum
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk) tick = 1'b1;
            repeat (4) @(negedge ref_clk);
            tick = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    endtask
endmodule

// ---- test/frt_tick_timer_bench.sv ----
// Register-level tests of the tick timer
module frt_tick_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_FLG = 8'hC6, A_EN = 8'hCC, A_CLR = 8'hE2;
    localparam logic [7:0] A_LO = 8'hE3, A_HI = 8'hE4;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [3:0] io_wdata = 4'h0;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    wire        tick_256hz;
    wire  [3:0] io_rdata;
    wire        irq_out;
    wire        counter_clear_strobe;
    int         n_mismatch = 0;
    int         tests_run = 0;
    int         cycles = 0;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    // Short hold window keeps the timeout case quick
    frt_tick_timer #(.HOLD_CYCLES(20)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .tick_256hz(tick_256hz), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .irq_out(irq_out), .counter_clear_strobe(counter_clear_strobe));
    frt_osc_model i_osc (.ref_clk(ref_clk), .tick(tick_256hz));
    task automatic cmp(input string nm, input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        @(negedge ref_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        cmp($sformatf("read %h", a), io_rdata, e);
    endtask
    // Ticks, then room for the count, flag and request to land
    task automatic ticks(input int n);
        i_osc.send(n);
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, well above the roughly 2800 cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(A_FLG, 4'h0);
        rd(A_EN, 4'h0);
        rd(A_LO, 4'h0);
        rd(A_HI, 4'h0);
        rd(A_CLR, 4'h0);
        done("reset");
        wr(A_EN, 4'hA);
        rd(A_EN, 4'hA);
        wr(A_FLG, 4'hF);
        rd(A_FLG, 4'h0);
        wr(A_LO, 4'h5);
        rd(A_LO, 4'h0);
        done("access");
        ticks(43);
        cmp("irq_out", {3'h0, irq_out}, 4'h1);
        rd(A_LO, 4'hB);
        rd(A_HI, 4'h2);
        rd(A_FLG, 4'h3);
        rd(A_FLG, 4'h0);
        cmp("irq_out", {3'h0, irq_out}, 4'h0);
        done("count and flags");
        wr(A_CLR, 4'h0);
        cmp("counter_clear_strobe", {3'h0, counter_clear_strobe}, 4'h0);
        rd(A_LO, 4'hB);
        wr(A_CLR, 4'h1);
        cmp("counter_clear_strobe", {3'h0, counter_clear_strobe}, 4'h1);
        rd(A_LO, 4'h0);
        rd(A_HI, 4'h0);
        rd(A_FLG, 4'h0);
        done("clear");
        wr(A_EN, 4'h0);
        ticks(256);
        cmp("irq_out", {3'h0, irq_out}, 4'h0);
        rd(A_FLG, 4'hF);
        rd(A_LO, 4'h0);
        rd(A_HI, 4'h0);
        done("wrap");
        wr(A_CLR, 4'h1);
        ticks(15);
        rd(A_LO, 4'hF);
        i_osc.send(1);
        rd(A_HI, 4'h0);
        rd(A_HI, 4'h1);
        ticks(15);
        rd(A_LO, 4'hF);
        i_osc.send(1);
        repeat (25) @(negedge ref_clk);
        rd(A_HI, 4'h2);
        done("carry hold");
        results();
    end
endmodule
